// [logic/spi_master_transmit_path.sv]
// serial master with transmit and receive queues behind an axi4-lite slave
// assumes slaves on the far side keep to the select discipline
// Contract
// - shift out msb first while shifting one new bit in
// - separate two-byte transmit and receive queues, each reachable by dma
// - launch bits on the programmed edge, capture on the opposite edge
// - master makes the serial clock; all parties share its polarity
// - each sampled bit enters as lsb, older bits move up
// - after a segment, push the received byte and reload when data waits
// - send dummy data when transmit request clear, drop input when store clear
// - segments of one to eight bits give any total bit count
// - with nothing left to send, stop the clock and release select
// - only one slave select low at a time, one line per slave
// - serial output goes to the pin and to internal cell and modulator
// - transmit request set and store clear means transmit-only mode
// - trigger select one with transmit request set: run whenever the transmit queue holds data and, with store set, the receive queue has room
// - trigger select one with transmit request set: each transfer decrements count, wrapping past zero
// - transmit-only mode never writes the receive queue
// - trigger select zero: wait for a count write, stop at zero
// - count write starts; queue drained, pause for more data until count ends
`timescale 1ns/10ps
module spi_master_transmit_path import spi_pkg::*; #(
	parameter int NUM_SS = 4
) (
	input  wire logic              CLK_SYS,
	input  wire logic              RESET,
	input  wire logic              CE,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [AXI_AW-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	output logic      [1:0]        S_AXI_BRESP,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	input  wire logic [AXI_AW-1:0] S_AXI_ARADDR,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	output logic      [31:0]       S_AXI_RDATA,
	output logic      [1:0]        S_AXI_RRESP,
	input  wire byte_beat_s        DMA_TX,
	output logic                   DMA_TX_READY,
	output byte_beat_s             DMA_RX,
	input  wire logic              DMA_RX_READY,
	output logic                   SCK,
	output logic                   SDO,
	output logic                   SERIAL_OUT_INTERNAL,
	input  wire logic              SDI,
	output logic      [NUM_SS-1:0] SS_N
);
	// ************************************************************
	// state
	// ************************************************************
	typedef logic [NUM_SS-1:0] select_t;

	typedef struct packed {
		logic [31:0]        ctrl;
		logic [COUNT_W-1:0] count;
		logic               aw_got;
		logic [AXI_AW-1:0]  aw_addr;
		logic               w_got;
		logic [31:0]        w_data;
		logic [3:0]         w_strb;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
		xfer_e              xfer;
		logic [7:0]         tick;
		logic [3:0]         bit_left;
		logic [7:0]         shreg;
		logic               sck;
		logic               sdo;
		logic               session;
		select_t            sel_n;
	} top_state_s;

	top_state_s s;
	top_state_s next_s;

	logic       sdi_sync;
	logic       tx_in_valid;
	logic [7:0] tx_in_data;
	logic       tx_in_ready;
	logic       tx_out_valid;
	logic [7:0] tx_out_data;
	logic       tx_out_ready;
	logic [1:0] tx_level;
	logic       rx_in_valid;
	logic [7:0] rx_in_data;
	logic       rx_in_ready;
	logic       rx_out_valid;
	logic [7:0] rx_out_data;
	logic       rx_out_ready;
	logic [1:0] rx_level;

	logic       en;
	logic       transmit_request_bit;
	logic       receive_store_bit;
	logic       trig;
	logic       idle_lvl;
	logic       lead;
	logic [3:0] seg_len;
	logic [7:0] half;
	logic       tx_only;
	logic       do_write;
	logic       bus_tx_write;
	logic       ar_take;
	logic       bus_rx_read;
	logic       go;
	logic       count_ok;
	logic       paused;
	logic [7:0] sh_next;
	logic [31:0] status;

	// ************************************************************
	// queues and pin synchroniser
	// ************************************************************
	pin_sync #(.WIDTH(1)) u_sdi_sync (
		.clk  (CLK_SYS),
		.rst  (RESET),
		.ce   (CE),
		.pin  (SDI),
		.sync (sdi_sync)
	);

	byte_queue #(.WIDTH(8), .DEPTH(QUEUE_DEPTH)) u_transmit_queue (
		.clk       (CLK_SYS),
		.rst       (RESET),
		.ce        (CE),
		.in_valid  (tx_in_valid),
		.in_data   (tx_in_data),
		.in_ready  (tx_in_ready),
		.out_valid (tx_out_valid),
		.out_data  (tx_out_data),
		.out_ready (tx_out_ready),
		.level     (tx_level)
	);

	byte_queue #(.WIDTH(8), .DEPTH(QUEUE_DEPTH)) u_receive_queue (
		.clk       (CLK_SYS),
		.rst       (RESET),
		.ce        (CE),
		.in_valid  (rx_in_valid),
		.in_data   (rx_in_data),
		.in_ready  (rx_in_ready),
		.out_valid (rx_out_valid),
		.out_data  (rx_out_data),
		.out_ready (rx_out_ready),
		.level     (rx_level)
	);

	// ************************************************************
	// control fields
	// ************************************************************
	assign en       = s.ctrl[CTRL_EN];
	assign transmit_request_bit      = s.ctrl[CTRL_TXR];
	assign receive_store_bit      = s.ctrl[CTRL_RXR];
	assign trig     = s.ctrl[CTRL_TRIG];
	assign idle_lvl = s.ctrl[CTRL_IDLE];
	assign lead     = s.ctrl[CTRL_LEAD];
	assign tx_only  = transmit_request_bit && !receive_store_bit;
	// field value 0 means a full byte
	assign seg_len  = (s.ctrl[CTRL_SEG_LO +: 3] == 3'h0) ? SEG_FULL
		: {1'b0, s.ctrl[CTRL_SEG_LO +: 3]};
	// halves shorter than the synchroniser delay would sample stale input
	assign half     = (s.ctrl[CTRL_DIV_LO +: 8] < HALF_MIN) ? HALF_MIN
		: s.ctrl[CTRL_DIV_LO +: 8];

	// ************************************************************
	// bus handshakes and queue access
	// ************************************************************
	assign S_AXI_AWREADY = CE && !s.aw_got && !s.bvalid;
	assign S_AXI_WREADY  = CE && !s.w_got && !s.bvalid;
	assign S_AXI_ARREADY = CE && !s.rvalid;
	assign S_AXI_BVALID  = s.bvalid;
	assign S_AXI_BRESP   = s.bresp;
	assign S_AXI_RVALID  = s.rvalid;
	assign S_AXI_RDATA   = s.rdata;
	assign S_AXI_RRESP   = s.rresp;

	assign do_write     = CE && s.aw_got && s.w_got;
	assign bus_tx_write = do_write && (s.aw_addr == OFS_TXDATA) && s.w_strb[0];
	assign ar_take      = S_AXI_ARVALID && S_AXI_ARREADY;
	assign bus_rx_read  = ar_take && (S_AXI_ARADDR == OFS_RXDATA);

	// the bus wins a queue port over dma in the same cycle
	assign tx_in_valid  = bus_tx_write || DMA_TX.valid;
	assign tx_in_data   = bus_tx_write ? s.w_data[7:0] : DMA_TX.data;
	assign DMA_TX_READY = tx_in_ready && !bus_tx_write;
	assign DMA_RX.valid = rx_out_valid && !bus_rx_read;
	assign DMA_RX.data  = rx_out_data;
	assign rx_out_ready = bus_rx_read || DMA_RX_READY;

	assign status = {25'h0000000, tx_only, s.session, (s.xfer != X_IDLE),
		(rx_level == 2'(QUEUE_DEPTH)), !rx_out_valid,
		(tx_level == 2'(QUEUE_DEPTH)), (tx_level == 2'h0)};

	// ************************************************************
	// engine start conditions
	// ************************************************************
	assign count_ok = (trig && transmit_request_bit) ? 1'b1 : (s.count != '0);
	assign go       = en && (!transmit_request_bit || tx_out_valid) && count_ok
		&& (!receive_store_bit || rx_in_ready);
	// counted transfer with count left waits with select held
	assign paused   = en && !(trig && transmit_request_bit) && (s.count != '0);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_s       = s;
		tx_out_ready = 1'b0;
		rx_in_valid  = 1'b0;
		rx_in_data   = s.shreg;
		sh_next      = {s.shreg[6:0], sdi_sync};

		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_s.aw_got  = 1'b1;
			next_s.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_s.w_got  = 1'b1;
			next_s.w_data = S_AXI_WDATA;
			next_s.w_strb = S_AXI_WSTRB;
		end
		if (s.bvalid && S_AXI_BREADY) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && S_AXI_RREADY) begin
			next_s.rvalid = 1'b0;
		end

		// ------------------------------------------------ engine
		case (s.xfer)
			X_IDLE: begin
				next_s.sck = idle_lvl;
				if (go) begin
					next_s.shreg    = transmit_request_bit ? tx_out_data : DUMMY_BYTE;
					tx_out_ready    = transmit_request_bit;
					next_s.bit_left = seg_len;
					next_s.tick     = 8'h00;
					next_s.session  = 1'b1;
					// one-hot low keeps every other slave released
					next_s.sel_n    = ~(select_t'(1) << s.ctrl[CTRL_SEL_LO +: 4]);
					next_s.count    = s.count - COUNT_W'(1);
					if (!lead) begin
						next_s.sdo = transmit_request_bit ? tx_out_data[7] : DUMMY_BYTE[7];
					end
					next_s.xfer = X_FIRST;
				end else if (!paused) begin
					next_s.session = 1'b0;
					next_s.sel_n   = '1;
				end
			end
			X_FIRST: begin
				next_s.tick = s.tick + 8'h01;
				if (s.tick == half - 8'h01) begin
					next_s.tick = 8'h00;
					next_s.sck  = !idle_lvl;
					next_s.xfer = X_SECOND;
					if (lead) begin
						next_s.sdo = s.shreg[7];
					end else begin
						next_s.shreg = sh_next;
					end
				end
			end
			X_SECOND: begin
				next_s.tick = s.tick + 8'h01;
				if (s.tick == half - 8'h01) begin
					next_s.tick     = 8'h00;
					next_s.sck      = idle_lvl;
					next_s.bit_left = s.bit_left - 4'h1;
					if (lead) begin
						next_s.shreg = sh_next;
						rx_in_data   = sh_next;
					end else begin
						next_s.sdo = s.shreg[7];
					end
					if (s.bit_left == 4'h1) begin
						// the shifter still holds unsent transmit bits above a short segment
						rx_in_data  = (lead ? sh_next : s.shreg) & ~(8'hFF << seg_len);
						// the store bit alone gates the push, so transmit-only drops it
						rx_in_valid = receive_store_bit;
						next_s.xfer = X_IDLE;
					end else begin
						next_s.xfer = X_FIRST;
					end
				end
			end
			default: begin
				next_s.xfer = X_IDLE;
			end
		endcase

		// ------------------------------------------------ bus write
		if (do_write) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = RESP_OKAY;
			if (s.aw_addr == OFS_CTRL) begin
				next_s.ctrl = apply_strb(s.ctrl, s.w_data, s.w_strb) & CTRL_MASK;
			end else if (s.aw_addr == OFS_COUNT) begin
				// a count write overrides the engine's decrement and starts a run
				next_s.count = COUNT_W'(apply_strb(32'(s.count), s.w_data, s.w_strb));
			end else if (s.aw_addr == OFS_TXDATA) begin
				if (s.w_strb[0] && !tx_in_ready) begin
					next_s.bresp = RESP_SLVERR;
				end
			end else if (s.aw_addr == OFS_RXDATA || s.aw_addr == OFS_STATUS) begin
				next_s.bresp = RESP_OKAY;
			end else begin
				next_s.bresp = RESP_SLVERR;
			end
		end

		// ------------------------------------------------ bus read
		if (ar_take) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = RESP_OKAY;
			if (S_AXI_ARADDR == OFS_CTRL) begin
				next_s.rdata = s.ctrl;
			end else if (S_AXI_ARADDR == OFS_COUNT) begin
				next_s.rdata = 32'(s.count);
			end else if (S_AXI_ARADDR == OFS_TXDATA) begin
				next_s.rdata = 32'h00000000;
			end else if (S_AXI_ARADDR == OFS_RXDATA) begin
				next_s.rdata = rx_out_valid ? {24'h000000, rx_out_data} : 32'h00000000;
			end else if (S_AXI_ARADDR == OFS_STATUS) begin
				next_s.rdata = status;
			end else begin
				next_s.rdata = 32'h00000000;
				next_s.rresp = RESP_SLVERR;
			end
		end

		if (!en) begin
			next_s.xfer    = X_IDLE;
			next_s.session = 1'b0;
			next_s.sel_n   = '1;
			next_s.sck     = idle_lvl;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			s       <= '0;
			s.ctrl  <= CTRL_RESET;
			s.count <= COUNT_RESET;
			s.sel_n <= '1;
		end else if (CE) begin
			s <= next_s;
		end
	end

	// ************************************************************
	// pins
	// ************************************************************
	assign SCK                 = s.sck;
	assign SDO                 = s.sdo;
	assign SERIAL_OUT_INTERNAL = s.sdo;
	assign SS_N                = s.sel_n;
endmodule // spi_master_transmit_path

// [logic/spi_pkg.sv]
// constants and carrier types for the serial master transmit path
// assumes a single system clock domain and an axi4-lite register bus
package spi_pkg;

	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam int          AXI_AW      = 8;
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_COUNT   = 8'h04;
	localparam logic [7:0]  OFS_TXDATA  = 8'h08;
	localparam logic [7:0]  OFS_RXDATA  = 8'h0C;
	localparam logic [7:0]  OFS_STATUS  = 8'h10;

	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	// ************************************************************
	// control word fields
	// ************************************************************
	localparam int          CTRL_EN     = 0;
	localparam int          CTRL_TXR    = 1;
	localparam int          CTRL_RXR    = 2;
	localparam int          CTRL_TRIG   = 3;
	localparam int          CTRL_IDLE   = 4;
	localparam int          CTRL_LEAD   = 5;
	localparam int          CTRL_SEG_LO = 8;
	localparam int          CTRL_SEL_LO = 12;
	localparam int          CTRL_DIV_LO = 16;
	localparam logic [31:0] CTRL_MASK   = 32'h00FF_FF3F;
	localparam logic [31:0] CTRL_RESET  = 32'h0003_0002;

	// ************************************************************
	// status word fields
	// ************************************************************
	localparam int          ST_TX_EMPTY = 0;
	localparam int          ST_TX_FULL  = 1;
	localparam int          ST_RX_EMPTY = 2;
	localparam int          ST_RX_FULL  = 3;
	localparam int          ST_BUSY     = 4;
	localparam int          ST_SELECT   = 5;
	localparam int          ST_TX_ONLY  = 6;

	// ************************************************************
	// timing and data constants
	// ************************************************************
	localparam int          COUNT_W     = 16;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam int          QUEUE_DEPTH = 2;
	localparam logic [7:0]  HALF_MIN    = 8'h03;
	localparam logic [7:0]  DUMMY_BYTE  = 8'h00;
	localparam logic [3:0]  SEG_FULL    = 4'h8;

	typedef enum logic [1:0] {X_IDLE, X_FIRST, X_SECOND} xfer_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byte_beat_s;

	function automatic logic [31:0] apply_strb(input logic [31:0] old_word,
			input logic [31:0] new_word, input logic [3:0] strb);
		logic [31:0] res;
		res = old_word;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return res;
	endfunction

endpackage

// [logic/pin_sync.sv]
// two-stage synchroniser for pins arriving from outside the clock domain
// assumes the consumer tolerates two cycles of latency
`timescale 1ns/10ps
module pin_sync import spi_pkg::*; #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] sync
);
	typedef struct packed {
		logic [WIDTH-1:0] stage2;
		logic [WIDTH-1:0] stage1;
	} sync_state_s;

	sync_state_s s;
	sync_state_s next_s;

	// stage1 feeds stage2 only; nothing else reads it
	always_comb begin
		next_s        = s;
		next_s.stage1 = pin;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign sync = s.stage2;
endmodule // pin_sync

// [logic/byte_queue.sv]
// small first-in first-out queue with valid/ready on both sides
// assumes one clock; pushes and pops only take effect while ce is high
`timescale 1ns/10ps
module byte_queue import spi_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = QUEUE_DEPTH
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         ce,
	input  wire logic                         in_valid,
	input  wire logic [WIDTH-1:0]             in_data,
	output logic                              in_ready,
	output logic                              out_valid,
	output logic      [WIDTH-1:0]             out_data,
	input  wire logic                         out_ready,
	output logic      [$clog2(DEPTH+1)-1:0]   level
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               rd;
		logic [CW-1:0]               cnt;
	} queue_state_s;

	queue_state_s s;
	queue_state_s next_s;
	logic         push;
	logic         pop;
	int           wr_idx;

	assign in_ready  = ce && (int'(s.cnt) != DEPTH);
	assign out_valid = ce && (s.cnt != '0);
	assign out_data  = s.mem[s.rd];
	assign level     = s.cnt;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		next_s = s;
		wr_idx = (int'(s.rd) + int'(s.cnt)) % DEPTH;
		if (push) begin
			next_s.mem[wr_idx] = in_data;
		end
		if (pop) begin
			next_s.rd = PW'((int'(s.rd) + 1) % DEPTH);
		end
		if (push && !pop) begin
			next_s.cnt = s.cnt + CW'(1);
		end else if (pop && !push) begin
			next_s.cnt = s.cnt - CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule // byte_queue

// [dv/spi_props.sv]
// port assertions for the serial master
// assumes it is bound into the design top and sees only its ports
`timescale 1ns/10ps
module spi_props import spi_pkg::*; #(
	parameter int NUM_SS = 4
) (
	input wire logic              CLK_SYS,
	input wire logic              RESET,
	input wire logic              S_AXI_AWVALID,
	input wire logic              S_AXI_AWREADY,
	input wire logic              S_AXI_WVALID,
	input wire logic              S_AXI_WREADY,
	input wire logic              S_AXI_BVALID,
	input wire logic              S_AXI_BREADY,
	input wire logic              S_AXI_ARVALID,
	input wire logic              S_AXI_ARREADY,
	input wire logic              S_AXI_RVALID,
	input wire byte_beat_s        DMA_RX,
	input wire logic              DMA_RX_READY,
	input wire logic              SCK,
	input wire logic              SDO,
	input wire logic              SERIAL_OUT_INTERNAL,
	input wire logic [NUM_SS-1:0] SS_N
);
	// ****
	// bus and link relations
	// ****
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);
	sequence aw_w_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence exec_then_b;
		!S_AXI_BVALID ##1 S_AXI_BVALID;
	endsequence
	sequence sck_edge_sel;
		!(&SS_N) && $changed(SCK);
	endsequence
	one_select_a: assert property ($onehot0(~SS_N))
		else $error("two slave selects low together");
	internal_copy_a: assert property (SERIAL_OUT_INTERNAL == SDO)
		else $error("internal serial copy differs from pin");
	reset_idle_a: assert property ($fell(RESET) |-> &SS_N && !SCK && !S_AXI_BVALID)
		else $error("link not idle after reset");
	sck_half_a: assert property (sck_edge_sel |=> $stable(SCK) [*2])
		else $error("serial clock half period too short");
	write_answer_a: assert property (aw_w_taken |=> exec_then_b)
		else $error("write response not two cycles after request");
	read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read data not one cycle after request");
	b_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response kept after acceptance");
	rx_hold_a: assert property (DMA_RX.valid && !DMA_RX_READY && !S_AXI_RVALID
		&& !(S_AXI_ARVALID && S_AXI_ARREADY) |=> $stable(DMA_RX.data)
		&& (DMA_RX.valid || S_AXI_ARVALID && S_AXI_ARREADY))
		else $error("receive head lost without a pop");
endmodule // spi_props

// [dv/spi_slave_model.sv]
// behavioural serial slave: shifts a preset byte out, records what it hears
// assumes half periods of several system cycles
`timescale 1ns/10ps
module spi_slave_model (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sel_n,
	input  wire logic       idle,
	input  wire logic       lead,
	input  wire logic [7:0] tx_byte,
	output logic            miso,
	output logic      [7:0] heard
);
	logic [7:0] shift;
	task automatic launch();
		miso = shift[7];
		shift = {shift[6:0], 1'b0};
	endtask
	initial begin
		{miso, heard, shift} = '0;
	end
	always @(negedge sel_n) begin
		shift = tx_byte;
		if (!lead) launch();
	end
	// no pull on the line: a released slave shows the inverse, never a stale bit
	always @(posedge sel_n) miso = ~miso;
	always @(sck) begin
		if (!sel_n) begin
			if ((sck != idle) ^ lead) heard = {heard[6:0], mosi};
			else launch();
		end
	end
endmodule // spi_slave_model

// [dv/testbench.sv]
// bench for the serial master: bus tasks, a slave model and a table of transfers
// assumes write strobes stay fixed high and CE stays high except in the freeze check
`timescale 1ns/10ps
module testbench import spi_pkg::*; ;
	localparam int NUM_SS = 4;
	typedef struct {
		logic [31:0] ctl;
		logic [7:0]  tx, sb, msk, got, rx;
	} row_s;
	logic              CLK_SYS, RESET, CE, SCK, SDO, SERIAL_OUT_INTERNAL, SDI, idle, lead;
	logic              S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic              S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	logic              S_AXI_RVALID, S_AXI_RREADY, DMA_TX_READY, DMA_RX_READY;
	logic [AXI_AW-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0]       S_AXI_WDATA, S_AXI_RDATA, rd;
	logic [3:0]        S_AXI_WSTRB;
	logic [1:0]        S_AXI_BRESP, S_AXI_RRESP, rr;
	logic [NUM_SS-1:0] SS_N;
	logic [7:0]        sb, heard;
	byte_beat_s        DMA_TX, DMA_RX;
	int                num_errors, checks_done, cyc;
	// dummy row first: the count must be zero before it, or it runs at once
	row_s              rows [6] = '{
		'{32'h0003_000D, 8'h00, 8'h81, 8'hFF, DUMMY_BYTE, 8'h81},
		'{32'h0003_000F, 8'hA5, 8'h3C, 8'hFF, 8'hA5, 8'h3C},
		'{32'h0003_131F, 8'hC3, 8'h96, 8'h07, 8'h06, 8'h04},
		'{32'h0003_212F, 8'h80, 8'hFF, 8'h01, 8'h01, 8'h01},
		'{32'h0004_303F, 8'h5A, 8'hC9, 8'hFF, 8'h5A, 8'hC9},
		'{32'h0003_000B, 8'hE7, 8'h55, 8'hFF, 8'hE7, 8'h00}};

	spi_master_transmit_path #(.NUM_SS(NUM_SS)) spi_master_transmit_path_i (.*);
	spi_slave_model spi_slave_model_i (.sck(SCK), .mosi(SDO), .sel_n(&SS_N), .idle(idle),
		.lead(lead), .tx_byte(sb), .miso(SDI), .heard(heard));

	// ****
	// tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		@(posedge CLK_SYS);
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		{aw, w} = 2'b00;
		while (!(aw && w)) begin
			@(posedge CLK_SYS);
			if (!aw && S_AXI_AWREADY) begin
				aw = 1'b1;
				S_AXI_AWVALID <= 1'b0;
			end
			if (!w && S_AXI_WREADY) begin
				w = 1'b1;
				S_AXI_WVALID <= 1'b0;
			end
		end
		do @(posedge CLK_SYS); while (!S_AXI_BVALID);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge CLK_SYS);
		{S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
		S_AXI_ARADDR <= a;
		do @(posedge CLK_SYS); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'b0;
		do @(posedge CLK_SYS); while (!S_AXI_RVALID);
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask
	task automatic wait_done(input logic [3:0] idx);
		while (&SS_N) @(posedge CLK_SYS);
		chk(32'(SS_N ^ (4'h1 << idx)), 32'hF);
		while (!(&SS_N)) @(posedge CLK_SYS);
		repeat (4) @(posedge CLK_SYS);
	endtask
	task automatic chk_reset();
		axi_rd(OFS_CTRL, rd, rr);
		chk(rd, CTRL_RESET);
		axi_rd(OFS_COUNT, rd, rr);
		chk(rd, 32'(COUNT_RESET));
		axi_rd(OFS_STATUS, rd, rr);
		chk(rd, 32'h45);
		chk(32'({SCK, SS_N}), 32'hF);
	endtask

	// ****
	// clock, timeout and sequence
	// ****
	initial begin
		CLK_SYS = 1'b0;
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		{RESET, CE} = 2'b11;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
		S_AXI_WSTRB = 4'hF;
		{DMA_TX, DMA_RX_READY, idle, lead, sb} = '0;
		repeat (10) @(posedge CLK_SYS);
		RESET <= 1'b0;
		chk_reset();
		foreach (rows[i]) begin
			idle <= rows[i].ctl[CTRL_IDLE];
			lead <= rows[i].ctl[CTRL_LEAD];
			sb <= rows[i].sb;
			axi_wr(OFS_CTRL, rows[i].ctl, rr);
			if (rows[i].ctl[CTRL_TXR]) axi_wr(OFS_TXDATA, 32'(rows[i].tx), rr);
			else axi_wr(OFS_COUNT, 32'h1, rr);
			wait_done(rows[i].ctl[15:12]);
			chk(32'(heard & rows[i].msk), 32'(rows[i].got));
			axi_rd(OFS_RXDATA, rd, rr);
			chk(rd, 32'(rows[i].rx));
		end
		axi_rd(OFS_COUNT, rd, rr);
		chk(rd, 32'hFFFB);
		// counted run: two queued, third refused, pause until the last byte
		axi_wr(OFS_COUNT, 32'h0, rr);
		axi_wr(OFS_CTRL, 32'h0003_0003, rr);
		axi_wr(OFS_TXDATA, 32'h11, rr);
		axi_wr(OFS_TXDATA, 32'h22, rr);
		axi_wr(OFS_TXDATA, 32'h33, rr);
		chk(32'(rr), 32'(RESP_SLVERR));
		repeat (40) @(posedge CLK_SYS);
		chk(32'(SS_N), 32'hF);
		axi_wr(OFS_COUNT, 32'h3, rr);
		repeat (150) @(posedge CLK_SYS);
		chk(32'({SCK, SS_N}), 32'hE);
		axi_rd(OFS_COUNT, rd, rr);
		chk(rd, 32'h1);
		axi_wr(OFS_TXDATA, 32'h44, rr);
		wait_done(4'h0);
		chk(32'(heard), 32'h44);
		axi_rd(OFS_COUNT, rd, rr);
		chk(rd, 32'h0);
		// queues through the dma side
		axi_wr(OFS_CTRL, 32'h0003_000F, rr);
		sb <= 8'hD2;
		DMA_TX <= '{1'b1, 8'h6B};
		do @(posedge CLK_SYS); while (DMA_TX_READY !== 1'b1);
		DMA_TX <= '0;
		wait_done(4'h0);
		chk(32'(heard), 32'h6B);
		chk(32'(DMA_RX), 32'h1D2);
		DMA_RX_READY <= 1'b1;
		@(posedge CLK_SYS);
		DMA_RX_READY <= 1'b0;
		axi_rd(8'h20, rd, rr);
		chk({rd[29:0], rr}, 32'(RESP_SLVERR));
		axi_wr(8'h24, 32'h1, rr);
		chk(32'(rr), 32'(RESP_SLVERR));
		// reset in mid transfer
		axi_wr(OFS_TXDATA, 32'h99, rr);
		while (&SS_N) @(posedge CLK_SYS);
		repeat (5) @(posedge CLK_SYS);
		// clock enable low must freeze the link and drop every bus ready
		CE <= 1'b0;
		@(posedge CLK_SYS);
		rd = 32'({SCK, SDO, SS_N});
		repeat (20) @(posedge CLK_SYS);
		chk(32'({SCK, SDO, SS_N}), rd);
		chk(32'({S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY}), 32'h0);
		CE <= 1'b1;
		RESET <= 1'b1;
		@(posedge CLK_SYS);
		RESET <= 1'b0;
		chk_reset();
		wrap_up();
	end
endmodule // testbench

bind spi_master_transmit_path spi_props #(.NUM_SS(NUM_SS)) spi_props_i (.*);
